// *** pkg/acp_pkg.sv ***
// Package: register map, timing and CRC helpers for the serial AFE host
`default_nettype none
package acp_pkg;
  // Host register map (byte addresses on the local port)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CFG    = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_WDATA  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA  = 8'h14;
  localparam logic [7:0] OFS_RXCRC  = 8'h18;

  // CTRL bits (write-only pulses)
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_ABORT = 1;
  localparam int unsigned CTRL_SYNC  = 2;

  // CFG fields
  localparam int unsigned CFG_DEV    = 0;
  localparam int unsigned CFG_RW     = 1;
  localparam int unsigned CFG_CRC    = 2;
  localparam int unsigned CFG_NB_LSB = 3;
  localparam logic [2:0]  MAX_DATA_BYTES = 3'h4;

  // STATUS bits
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_DONE     = 1;
  localparam int unsigned ST_CMD_ERR  = 2;
  localparam int unsigned ST_DATA_ERR = 3;
  localparam int unsigned ST_READY    = 4;
  localparam int unsigned ST_ALARM    = 5;
  localparam int unsigned ST_PIN2     = 6;
  localparam int unsigned ST_SYNC     = 7;
  localparam int unsigned ST_ABORTED  = 8;

  // Reset values
  localparam logic        CFG_RST_BIT  = 1'b0;
  localparam logic [2:0]  CFG_RST_NB   = 3'h0;
  localparam logic [12:0] ADDR_RST     = 13'h0000;
  localparam logic [23:0] WDATA_RST    = 24'h000000;

  // Frame layout
  localparam int unsigned FRAME_MAX_BITS = 72;
  localparam logic [6:0]  CMD_BITS       = 7'h10;
  localparam logic [6:0]  DEVCRC_END     = 7'h1F;
  localparam logic [6:0]  DATA_START_CRC = 7'h20;
  localparam logic [6:0]  CRC_ONLY_BITS  = 7'h20;
  localparam logic [6:0]  CRC_FRAME_OVH  = 7'h28;

  // CRC-8: x^8 + x^2 + x + 1, zero start, MSB first, no final inversion
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Timing
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned SCLK_MAX_MHZ  = 32;
  localparam int unsigned HALF_CYC      =
    (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int unsigned DEV_SYSCLK_NS = 100;
  localparam int unsigned SYNC_MIN_NS   = 2 * DEV_SYSCLK_NS;
  localparam int unsigned SYNC_CYC      = (SYNC_MIN_NS + CLK_NS - 1) / CLK_NS;

  function automatic logic [7:0] crc8_bits(input logic [31:0] data,
                                           input logic [5:0]  nbits);
    logic [7:0] crc;
    crc = CRC_INIT;
    for (int i = 0; i < 32; i++)
    begin
      if (6'(i) < nbits)
      begin
        if (crc[7] ^ data[31-i])
          crc = {crc[6:0], 1'b0} ^ CRC_POLY;
        else
          crc = {crc[6:0], 1'b0};
      end
    end
    return crc;
  endfunction
endpackage
`default_nettype wire

// *** rtl/acp_crc8_ser.sv ***
// Serial CRC-8 engine fed one bit per enable, MSB first
`default_nettype none
module acp_crc8_ser (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       clear_i,
  input  wire logic       en_i,
  input  wire logic       bit_i,
  output logic      [7:0] crc_o
);
  logic fb;
  assign fb = crc_o[7] ^ bit_i;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      crc_o <= acp_pkg::CRC_INIT;
    else if (clear_i)
      crc_o <= acp_pkg::CRC_INIT;
    else if (en_i)
      crc_o <= {crc_o[6:0], 1'b0} ^ (fb ? acp_pkg::CRC_POLY : 8'h00);
  end
endmodule
`default_nettype wire

// *** rtl/acp_host_ctrl.sv ***
// Host controller that frames commands and register access to the AFE
//
// Local design decisions: strobed register access and the register offsets.
`default_nettype none
// Operation
// - First frame bit must equal the target device's address strap level.
// - Host holds each sync pulse at least 2 device clock periods.
// - Frame is select bit, read/write bit, 13 address bits, then data; the code also puts a zero bit between the address and the data.
// - Read/write bit is 0 for writes and commands, 1 for reads.
// - CRC byte is remainder over polynomial x^8+x^2+x+1.
// - With CRC on, a CRC byte follows the command and the data.
// - Host sends address word, its CRC, data, then data CRC.
// - Eight extra clocks after a CRC write return device data CRC.
// - CRC address word is select, read/write, address, trailing zero.
// - Raising chip select ends a frame; new frame needs a falling select.
// - Input sampled on falling clock, output changed on rising, max 32 MHz.
module acp_host_ctrl #(
  parameter int unsigned HALF_CYC = acp_pkg::HALF_CYC,
  parameter int unsigned SYNC_CYC = acp_pkg::SYNC_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             sclk_o,
  output logic             chip_select_n_o,
  output logic             mosi_o,
  input  wire logic        miso_i,
  input  wire logic        data_ready_out_i,
  input  wire logic        alarm_irq_n_i,
  input  wire logic        general_pin_two_i,
  output logic             sync_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_HIGH,
    ST_LOW,
    ST_GAP
  } acp_state_e;

  acp_state_e  st_q;
  logic [7:0]  cnt_q;
  logic [6:0]  bit_q;
  logic [6:0]  nbits_q;
  logic [71:0] tx_q;
  logic [71:0] rx_q;
  logic        cs_n_q;
  logic        sclk_q;
  logic        fcrc_q;
  logic        frw_q;
  logic        aborted_q;
  logic [2:0]  fnb_q;
  logic [7:0]  crca_q;

  // Configuration
  logic        dev_q;
  logic        rw_q;
  logic        crc_q;
  logic [2:0]  nb_q;
  logic [12:0] raddr_q;
  logic [23:0] wdat_q;

  // Results and sticky status
  logic [31:0] rdat_q;
  logic [7:0]  devcrc_q;
  logic [7:0]  rxcrc_q;
  logic        done_q;
  logic        cmd_err_q;
  logic        data_err_q;
  logic        ready_q;
  logic        abt_flag_q;

  // Pin synchronisers: miso, ready, alarm, pin two
  logic [3:0]  meta_q;
  logic [3:0]  pin_q;
  logic        ready_d1_q;

  logic [7:0]  sync_cnt_q;
  logic        sync_q;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // Idle levels: ready low, alarm high, so no false edge after reset
      meta_q     <= 4'h2;
      pin_q      <= 4'h2;
      ready_d1_q <= 1'b0;
    end
    else
    begin
      meta_q     <= {miso_i, data_ready_out_i, alarm_irq_n_i,
                     general_pin_two_i};
      pin_q      <= meta_q;
      ready_d1_q <= pin_q[2];
    end
  end

  logic miso_s;
  logic ready_rise;
  assign miso_s     = pin_q[3];
  assign ready_rise = pin_q[2] & ~ready_d1_q;

  // Local bus decode
  logic wr_ctrl;
  logic start_req;
  logic abort_req;
  logic sync_req;
  logic busy;
  logic stat_rd;
  assign wr_ctrl   = wr_i && (addr_i == acp_pkg::OFS_CTRL);
  assign start_req = wr_ctrl && wdata_i[acp_pkg::CTRL_START];
  assign abort_req = wr_ctrl && wdata_i[acp_pkg::CTRL_ABORT];
  assign sync_req  = wr_ctrl && wdata_i[acp_pkg::CTRL_SYNC];
  assign busy      = (st_q != ST_IDLE);
  assign stat_rd   = rd_i && (addr_i == acp_pkg::OFS_STATUS);

  // Configuration is frozen while a frame runs
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dev_q   <= acp_pkg::CFG_RST_BIT;
      rw_q    <= acp_pkg::CFG_RST_BIT;
      crc_q   <= acp_pkg::CFG_RST_BIT;
      nb_q    <= acp_pkg::CFG_RST_NB;
      raddr_q <= acp_pkg::ADDR_RST;
      wdat_q  <= acp_pkg::WDATA_RST;
    end
    else if (wr_i && !busy)
    begin
      if (addr_i == acp_pkg::OFS_CFG)
      begin
        dev_q <= wdata_i[acp_pkg::CFG_DEV];
        rw_q  <= wdata_i[acp_pkg::CFG_RW];
        crc_q <= wdata_i[acp_pkg::CFG_CRC];
        if (wdata_i[acp_pkg::CFG_NB_LSB +: 3] > acp_pkg::MAX_DATA_BYTES)
          nb_q <= acp_pkg::MAX_DATA_BYTES;
        else
          nb_q <= wdata_i[acp_pkg::CFG_NB_LSB +: 3];
      end
      if (addr_i == acp_pkg::OFS_ADDR)
        raddr_q <= wdata_i[12:0];
      if (addr_i == acp_pkg::OFS_WDATA)
        wdat_q <= wdata_i[23:0];
    end
  end

  // Frame image built from the configuration at start
  logic [15:0] addr_word;
  logic [5:0]  nbit_data;
  logic [31:0] data_m;
  logic [7:0]  crc_a;
  logic [7:0]  crc_d;
  logic [47:0] tail;
  logic [71:0] tx_img;
  logic [6:0]  frame_len;

  always_comb
  begin
    addr_word = {dev_q, rw_q, raddr_q, 1'b0};
    nbit_data = {nb_q, 3'b000};
    // Writes send the top bytes first, so a short write is a partial one
    data_m    = rw_q ? 32'h00000000 :
                ({wdat_q, 8'h00} & ~(32'hFFFFFFFF >> nbit_data));
    crc_a     = acp_pkg::crc8_bits({addr_word, 16'h0000},
                                   6'h10);
    crc_d     = acp_pkg::crc8_bits(data_m, nbit_data);
    tail      = {data_m, 16'h0000} | ({crc_d, 40'h0} >> nbit_data);
    if (crc_q)
    begin
      tx_img = {addr_word, crc_a, tail};
      if (nb_q == 3'h0)
        frame_len = acp_pkg::CRC_ONLY_BITS;
      else
        frame_len = acp_pkg::CRC_FRAME_OVH + 7'({nb_q, 3'b000});
    end
    else
    begin
      tx_img    = {addr_word, data_m, 24'h000000};
      frame_len = acp_pkg::CMD_BITS + 7'({nb_q, 3'b000});
    end
  end

  logic phase_end;
  logic samp;
  logic last;
  logic in_data;
  logic [71:0] rx_full;
  logic [7:0]  eng_crc;
  assign phase_end = (cnt_q == 8'(HALF_CYC - 1));
  assign samp      = (st_q == ST_LOW) && phase_end;
  assign last      = samp && (bit_q == nbits_q - 7'h01);
  assign rx_full   = {rx_q[70:0], miso_s};
  assign in_data   = fcrc_q && (bit_q >= acp_pkg::DATA_START_CRC) &&
                     (bit_q < acp_pkg::DATA_START_CRC + 7'({fnb_q, 3'b000}));

  // Only the data bytes of the frame reach the result register
  logic [31:0] rx_mask;
  assign rx_mask = ~(32'hFFFFFFFF << {fnb_q, 3'b000});

  // Data CRC of what the device returns, checked against its trailing byte
  acp_crc8_ser i_acp_crc8_ser (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .clear_i (start_req && !busy),
    .en_i    (samp && in_data),
    .bit_i   (miso_s),
    .crc_o   (eng_crc)
  );

  // Link sequencer: MOSI moves with the rising edge, MISO is read late
  // in the low phase so the synchroniser delay stays inside the bit
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q      <= ST_IDLE;
      cnt_q     <= 8'h00;
      bit_q     <= 7'h00;
      nbits_q   <= 7'h00;
      tx_q      <= 72'h0;
      rx_q      <= 72'h0;
      cs_n_q    <= 1'b1;
      sclk_q    <= 1'b0;
      fcrc_q    <= 1'b0;
      frw_q     <= 1'b0;
      fnb_q     <= 3'h0;
      crca_q    <= 8'h00;
      aborted_q <= 1'b0;
    end
    else if (abort_req && busy && st_q != ST_GAP)
    begin
      st_q      <= ST_GAP;
      cnt_q     <= 8'h00;
      cs_n_q    <= 1'b1;
      sclk_q    <= 1'b0;
      aborted_q <= 1'b1;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          if (start_req)
          begin
            st_q      <= ST_LEAD;
            cs_n_q    <= 1'b0;
            cnt_q     <= 8'h00;
            bit_q     <= 7'h00;
            nbits_q   <= frame_len;
            tx_q      <= tx_img;
            rx_q      <= 72'h0;
            fcrc_q    <= crc_q;
            frw_q     <= rw_q;
            fnb_q     <= nb_q;
            crca_q    <= crc_a;
            aborted_q <= 1'b0;
          end
        end
        ST_LEAD, ST_HIGH:
        begin
          cnt_q <= phase_end ? 8'h00 : cnt_q + 8'h01;
          if (phase_end)
          begin
            st_q   <= (st_q == ST_LEAD) ? ST_HIGH : ST_LOW;
            sclk_q <= (st_q == ST_LEAD);
          end
        end
        ST_LOW:
        begin
          cnt_q <= phase_end ? 8'h00 : cnt_q + 8'h01;
          if (samp)
          begin
            rx_q  <= rx_full;
            bit_q <= bit_q + 7'h01;
            if (last)
            begin
              st_q   <= ST_GAP;
              cs_n_q <= 1'b1;
            end
            else
            begin
              st_q   <= ST_HIGH;
              sclk_q <= 1'b1;
              tx_q   <= {tx_q[70:0], 1'b0};
            end
          end
        end
        ST_GAP:
        begin
          // Select stays high a half period so the next frame sees a fall
          cnt_q <= phase_end ? 8'h00 : cnt_q + 8'h01;
          if (phase_end)
            st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Frame results
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdat_q   <= 32'h00000000;
      devcrc_q <= 8'h00;
      rxcrc_q  <= 8'h00;
    end
    else if (samp)
    begin
      if (fcrc_q && bit_q == acp_pkg::DEVCRC_END)
        devcrc_q <= rx_full[7:0];
      if (last)
      begin
        rdat_q  <= (fcrc_q ? rx_full[39:8] : rx_full[31:0]) & rx_mask;
        rxcrc_q <= rx_full[7:0];
      end
    end
  end

  logic cmd_err_set;
  logic data_err_set;
  logic done_set;
  assign cmd_err_set  = samp && fcrc_q && bit_q == acp_pkg::DEVCRC_END &&
                        rx_full[7:0] != crca_q;
  assign data_err_set = last && fcrc_q && fnb_q != 3'h0 &&
                        rx_full[7:0] != eng_crc;
  assign done_set     = last;

  // Sticky status: a set in the clearing read cycle wins
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_q     <= 1'b0;
      cmd_err_q  <= 1'b0;
      data_err_q <= 1'b0;
      ready_q    <= 1'b0;
      abt_flag_q <= 1'b0;
    end
    else
    begin
      done_q     <= done_set     | (done_q     & ~stat_rd);
      cmd_err_q  <= cmd_err_set  | (cmd_err_q  & ~stat_rd);
      data_err_q <= data_err_set | (data_err_q & ~stat_rd);
      ready_q    <= ready_rise   | (ready_q    & ~stat_rd);
      abt_flag_q <= (abort_req && busy) | (abt_flag_q & ~stat_rd);
    end
  end

  // Sync pulse, stretched so the device's clock is sure to see it
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_cnt_q <= 8'h00;
      sync_q     <= 1'b0;
    end
    else if (sync_req && sync_cnt_q == 8'h00)
    begin
      sync_cnt_q <= 8'(SYNC_CYC);
      sync_q     <= 1'b1;
    end
    else if (sync_cnt_q > 8'h01)
      sync_cnt_q <= sync_cnt_q - 8'h01;
    else
    begin
      sync_cnt_q <= 8'h00;
      sync_q     <= 1'b0;
    end
  end

  // Register read port, data one cycle after the strobe
  logic [31:0] status_v;
  always_comb
  begin
    status_v = 32'h00000000;
    status_v[acp_pkg::ST_BUSY]     = busy;
    status_v[acp_pkg::ST_DONE]     = done_q;
    status_v[acp_pkg::ST_CMD_ERR]  = cmd_err_q;
    status_v[acp_pkg::ST_DATA_ERR] = data_err_q;
    status_v[acp_pkg::ST_READY]    = ready_q;
    status_v[acp_pkg::ST_ALARM]    = ~pin_q[1];
    status_v[acp_pkg::ST_PIN2]     = pin_q[0];
    status_v[acp_pkg::ST_SYNC]     = sync_q;
    status_v[acp_pkg::ST_ABORTED]  = abt_flag_q;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
    begin
      unique case (addr_i)
        acp_pkg::OFS_CFG:    rdata_o <= {26'h0, nb_q, crc_q, rw_q, dev_q};
        acp_pkg::OFS_ADDR:   rdata_o <= {19'h0, raddr_q};
        acp_pkg::OFS_WDATA:  rdata_o <= {8'h00, wdat_q};
        acp_pkg::OFS_STATUS: rdata_o <= status_v;
        acp_pkg::OFS_RDATA:  rdata_o <= rdat_q;
        acp_pkg::OFS_RXCRC:  rdata_o <= {16'h0000, devcrc_q, rxcrc_q};
        default:             rdata_o <= 32'h00000000;
      endcase
    end
  end

  assign sclk_o          = sclk_q;
  assign chip_select_n_o = cs_n_q;
  assign mosi_o          = tx_q[71];
  assign sync_o          = sync_q;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_start;
    st_q == ST_IDLE && start_req;
  endsequence
  sequence s_open;
    !cs_n_q && bit_q == 7'h00 && !sclk_q;
  endsequence

  a_start_opens: assert property (s_start |=> s_open)
    else $error("frame did not open after start");
  a_first_bit_dev: assert property (s_start |=> mosi_o == $past(dev_q))
    else $error("first bit is not the select bit");
  a_rw_second_bit: assert property (
    st_q == ST_HIGH && bit_q == 7'h01 |-> mosi_o == frw_q)
    else $error("second bit is not the read/write bit");
  a_clock_needs_cs: assert property (sclk_q |-> !cs_n_q)
    else $error("serial clock high while deselected");
  a_abort_closes: assert property (
    abort_req && (st_q == ST_HIGH || st_q == ST_LOW) |=>
    cs_n_q && !sclk_q ##1 cs_n_q)
    else $error("abort did not release select");
  a_mosi_steady: assert property (
    $fell(sclk_q) |-> $stable(mosi_o))
    else $error("data moved at the falling clock");
  a_frame_length: assert property (
    $rose(cs_n_q) && !aborted_q |-> bit_q == nbits_q)
    else $error("frame length differs from computed count");
  a_sync_width: assert property ($rose(sync_q) |=> sync_q)
    else $error("sync pulse shorter than two cycles");
  a_cmd_crc_flag: assert property (
    cmd_err_set |=> cmd_err_q ##1 (cmd_err_q || $past(stat_rd)))
    else $error("command CRC mismatch not flagged");
  a_data_crc_flag: assert property (data_err_set |=> data_err_q)
    else $error("data CRC mismatch not flagged");
endmodule
`default_nettype wire

// *** verification/acp_tb_pkg.sv ***
// Reference CRC-8 for the front-end model and the bench
`default_nettype none
package acp_tb_pkg;
  // Low nb bytes of d, zero start, MSB first, no final inversion
  function automatic logic [7:0] crc8(input logic [23:0] d, input int nb);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 8 * nb - 1; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // Status byte ahead of three data bytes, one running remainder
  function automatic logic [7:0] crc8s(input logic [7:0]  s,
                                       input logic [23:0] d);
    logic [7:0] c;
    c = crc8({16'h0000, s}, 1);
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
endpackage
`default_nettype wire

// *** verification/acp_dev_model.sv ***
// Behavioural model of the serial front end facing the host controller
`default_nettype none
module acp_dev_model (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic sclk_i,
  input  wire logic chip_select_n_i,
  input  wire logic mosi_i,
  input  wire logic sync_i,
  input  wire logic address_strap_pin_i,
  input  wire logic alarm_i,
  input  wire logic bad_crc_i,
  output logic      miso_o,
  output logic      data_ready_out_o,
  output logic      alarm_irq_n_o,
  output logic      general_pin_two_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] regs [4];
  logic [31:0] rx;
  logic [23:0] rdv;
  logic [15:0] aw;
  logic [7:0]  ca, rc, wc, sb;
  logic [39:0] rsp;
  logic [6:0]  cnt;
  logic [4:0]  dly = 5'h00;
  logic        err = 1'h0;
  logic        ok = 1'h0;
  logic        out_q = 1'h0;
  logic        drv_q = 1'h0;
  logic        sy_q = 1'h0;
  logic        crc_en;
  int          b;
  assign crc_en = regs[0][7];
  always @(negedge sclk_i)
  begin
    if (!chip_select_n_i)
    begin
      rx = {rx[30:0], mosi_i};
      cnt = cnt + 7'h01;
      if (cnt == 7'h10)
      begin
        aw = rx[15:0];
        ok = aw[15] == address_strap_pin_i;
        rdv = aw[2:1] == 2'h1 ? {23'h0, err} : regs[aw[2:1]];
        sb = {7'h61, err};
        ca = acp_tb_pkg::crc8({8'h00, aw}, 2);
        // Status prefix on: the data CRC also covers the status byte
        rc = regs[0][3] ? acp_tb_pkg::crc8s(sb, rdv)
                        : acp_tb_pkg::crc8(rdv, 3);
        rc = rc ^ {7'h00, bad_crc_i};
        rsp = regs[0][3] ? {sb, rdv, rc} : {rdv, rc, 8'h00};
        if (ok && aw[14] && aw[2:1] == 2'h1)
          err = 1'h0;
      end
      if (ok && crc_en && cnt == 7'h18 && rx[7:0] != ca)
      begin
        ok = 1'h0;
        err = 1'h1;
      end
      if (ok && !aw[14] && !crc_en && cnt[2:0] == 3'h0 && cnt > 7'h10
          && cnt <= 7'h28)
        regs[aw[2:1]][8 * (5 - cnt[6:3]) +: 8] = rx[7:0];
      if (ok && !aw[14] && crc_en && cnt == 7'h38)
      begin
        wc = acp_tb_pkg::crc8(rx[31:8], 3);
        if (wc == rx[7:0])
          regs[aw[2:1]] = rx[31:8];
        else
          err = 1'h1;
      end
    end
  end
  always @(posedge sclk_i)
  begin
    b = int'(cnt) - (crc_en ? 24 : 16);
    drv_q = ok && b >= 0 && (aw[14] || crc_en);
    if (b < 0)
      out_q = ~out_q;
    else if (!crc_en)
      out_q = b < 24 ? rdv[23 - b] : 1'h0;
    else if (b < 8)
      out_q = ca[7 - b];
    else if (aw[14])
      out_q = b < 48 ? rsp[47 - b] : 1'h0;
    else if (b < 32)
      out_q = rx[7];
    else if (b < 40)
      out_q = wc[39 - b];
  end
  // A released line shows the inverse level, never a stale copy
  assign miso_o = drv_q && !chip_select_n_i ? out_q : ~out_q;
  assign general_pin_two_o = regs[0][6] && err;
  // Pull-up and push-pull give the same level here
  assign alarm_irq_n_o = !alarm_i;
  // Device clock taken as the host clock; ready ends sixteen cycles past the sync
  assign data_ready_out_o = dly != 5'h00
    && dly <= (regs[0][4] ? 5'h08 : 5'h02);
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      regs = '{default: 24'h000000};
      err = 1'h0;
      cnt = 7'h00;
      dly <= 5'h00;
    end
    else if (sync_i && !sy_q && regs[0][5])
      dly <= 5'h10;
    else if (dly != 5'h00)
      dly <= dly - 5'h01;
    sy_q <= sync_i;
  end
  always @(posedge chip_select_n_i)
    cnt = 7'h00;
endmodule
`default_nettype wire

// *** verification/tb_acp_host_ctrl.sv ***
// Self-checking bench: host controller against the front-end model
`default_nettype none
module tb_acp_host_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'h0;
  logic        rd_i = 1'h0;
  logic [31:0] rdata_o, d, st;
  logic        sclk_o, chip_select_n_o, mosi_o, miso_i, sync_o;
  logic        data_ready_out_i, alarm_irq_n_i, general_pin_two_i;
  logic        alarm = 1'h0;
  logic        bad = 1'h0;
  int          num_errors = 0;
  int          n_checks = 0;
  int          k;
  acp_host_ctrl #(.HALF_CYC(2), .SYNC_CYC(4)) i_acp_host_ctrl (
    .clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .sclk_o, .chip_select_n_o, .mosi_o, .miso_i, .data_ready_out_i,
    .alarm_irq_n_i, .general_pin_two_i, .sync_o);
  acp_dev_model i_acp_dev_model (
    .clock_i, .rst_n_i, .sclk_i(sclk_o), .chip_select_n_i(chip_select_n_o),
    .mosi_i(mosi_o), .sync_i(sync_o), .address_strap_pin_i(1'h0),
    .alarm_i(alarm), .bad_crc_i(bad), .miso_o(miso_i),
    .data_ready_out_o(data_ready_out_i), .alarm_irq_n_o(alarm_irq_n_i),
    .general_pin_two_o(general_pin_two_i));
  initial
  begin
    forever #4 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1 d = rdata_o;
  endtask
  // Config word: bytes in [5:3], crc [2], read [1], select [0]
  task automatic xfer(input logic [31:0] c, a, v);
    for (k = 0; k == 0 || (d[0] && k < 99); k++)
      rd(acp_pkg::OFS_STATUS);
    wr(acp_pkg::OFS_CFG, c);
    wr(acp_pkg::OFS_ADDR, a);
    wr(acp_pkg::OFS_WDATA, v);
    wr(acp_pkg::OFS_CTRL, 32'h1);
    st = 32'h0;
    // Status reads clear sticky bits, so they are gathered here
    for (k = 0; k < 300 && !(st[1] && !d[0]); k++)
    begin
      rd(acp_pkg::OFS_STATUS);
      st = st | d;
    end
    // A frame that never finishes counts as a mismatch
    if (!(st[1] && !d[0]))
      num_errors++;
  endtask
  task automatic rback(input logic [31:0] c, a, exp);
    xfer(c, a, 32'h0);
    rd(acp_pkg::OFS_RDATA);
    chk(d, exp);
  endtask
  initial
  begin
    #300000;
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'h1;
    rd(8'h1C);
    chk(d, 32'h0);
    xfer(32'h18, 32'h2, 32'hA5B6C7);
    chk(st & 32'h10E, 32'h002);
    rback(32'h1A, 32'h2, 32'hA5B6C7);
    xfer(32'h08, 32'h2, 32'h110000);
    xfer(32'h19, 32'h2, 32'hFFFFFF);
    rback(32'h1A, 32'h2, 32'h11B6C7);
    wr(acp_pkg::OFS_CFG, 32'h18);
    wr(acp_pkg::OFS_WDATA, 32'h0);
    wr(acp_pkg::OFS_CTRL, 32'h1);
    repeat (80) @(posedge clock_i);
    wr(acp_pkg::OFS_CTRL, 32'h2);
    rd(acp_pkg::OFS_STATUS);
    chk(d & 32'h100, 32'h100);
    chk({31'h0, chip_select_n_o}, 32'h1);
    rback(32'h1A, 32'h2, 32'h11B6C7);
    xfer(32'h18, 32'h0, 32'h000020);
    wr(acp_pkg::OFS_CTRL, 32'h4);
    k = 0;
    repeat (12) @(posedge clock_i) k += int'(sync_o);
    chk(32'(k), 32'h4);
    repeat (20) @(posedge clock_i);
    rd(acp_pkg::OFS_STATUS);
    chk(d & 32'h10, 32'h10);
    alarm <= 1'h1;
    repeat (4) @(posedge clock_i);
    rd(acp_pkg::OFS_STATUS);
    chk(d & 32'h20, 32'h20);
    alarm <= 1'h0;
    xfer(32'h18, 32'h0, 32'h0000C0);
    xfer(32'h08, 32'h3, {8'h0, ~acp_tb_pkg::crc8(24'h0006, 2), 16'h0});
    rd(acp_pkg::OFS_STATUS);
    chk(d & 32'h40, 32'h40);
    rback(32'h1E, 32'h1, 32'h1);
    chk(st & 32'h0E, 32'h02);
    rd(acp_pkg::OFS_RXCRC);
    chk(d, {16'h0, acp_tb_pkg::crc8(24'h4002, 2),
      acp_tb_pkg::crc8(24'h1, 3)});
    rd(acp_pkg::OFS_STATUS);
    chk(d & 32'h40, 32'h0);
    xfer(32'h1C, 32'h3, 32'h123456);
    chk(st & 32'h0E, 32'h02);
    rd(acp_pkg::OFS_RXCRC);
    chk(d & 32'hFF, 32'(acp_tb_pkg::crc8(24'h123456, 3)));
    rback(32'h1E, 32'h3, 32'h123456);
    bad <= 1'h1;
    xfer(32'h1E, 32'h3, 32'h0);
    chk(st & 32'h0C, 32'h08);
    bad <= 1'h0;
    xfer(32'h04, 32'h3, 32'h0);
    chk(st & 32'h0E, 32'h02);
    rd(acp_pkg::OFS_RXCRC);
    chk(d, {16'h0, {2{acp_tb_pkg::crc8(24'h0006, 2)}}});
    xfer(32'h1C, 32'h0, 32'h0000C8);
    rback(32'h26, 32'h3, 32'hC2123456);
    chk(st & 32'h0E, 32'h02);
    conclude();
  end
endmodule
`default_nettype wire
